// *** dv/dsc_fm_model.sv ***
// Frame memory model answering the block's read fetches
`timescale 1ns/100ps
module dsc_fm_model (
   input wire logic [8:0] col_i,
   input wire logic [8:0] row_i,
   output logic [17:0] data_o
);
   // Fixed pattern per address; no reset input, so no reset can clear it
   assign data_o = {col_i[5:0] + 6'h11, row_i[5:0] + 6'h22,
                    col_i[5:0] ^ row_i[5:0] ^ 6'h33};
endmodule

// *** dv/dsc_top_test.sv ***
// Self-checking bench for the scroll, sync and access command block
`timescale 1ns/100ps
module dsc_top_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic soft_rst = 1'b0;
   logic wr_n = 1'b1;
   logic rd_n = 1'b1;
   logic dcs = 1'b1;
   logic [7:0] din = 8'h00;
   logic vb = 1'b0;
   logic hb = 1'b0;
   logic slp = 1'b0;
   logic [7:0] dout;
   logic doe;
   logic fsync;
   logic [8:0] fcol;
   logic [8:0] frow;
   logic frd;
   logic [17:0] fdata;
   logic [8:0] top;
   logic [8:0] scr;
   logic [8:0] bot;
   logic [7:0] mac;
   logic [7:0] sp [6] = '{8'h01, 8'h23, 8'h00, 8'h45, 8'h00, 8'h1E};
   logic [7:0] cwin [4] = '{8'h00, 8'h00, 8'h01, 8'h67};
   logic [7:0] rwin [4] = '{8'h00, 8'h00, 8'h01, 8'h85};
   int error_cnt = 0;
   int total_checks = 0;
   int fetch_cnt = 0;

   // 10 MHz core clock
   always #50 clk = ~clk;

   // Count fetch pulses mid-cycle, clear of the edge that launches them
   always @(negedge clk) begin
      if (frd === 1'b1) begin
         fetch_cnt++;
      end
   end

   dsc_top uut (.CLK_I(clk), .RESET_N_I(rst_n), .SOFT_RESET_I(soft_rst),
      .WR_N_I(wr_n), .RD_N_I(rd_n), .DATA_COMMAND_SELECT_I(dcs),
      .DATA_I(din), .DATA_O(dout), .DATA_OE_O(doe), .VBLANK_I(vb),
      .HBLANK_I(hb), .SLEEP_I(slp), .FRAME_SYNC_O(fsync), .FM_COL_O(fcol),
      .FM_ROW_O(frow), .FM_RD_O(frd), .FM_DATA_I(fdata),
      .TOP_FIXED_LINES_O(top), .SCROLL_AREA_LINES_O(scr),
      .BOTTOM_FIXED_LINES_O(bot), .MEMORY_ACCESS_CONTROL_O(mac));

   dsc_fm_model fm (.col_i(fcol), .row_i(frow), .data_o(fdata));

   // Pass n edges, then step clear of the edge before driving
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Data and select held well past the pin synchroniser lag
   task automatic wr(input logic dc, input logic [7:0] d);
      dcs = dc;
      din = d;
      wr_n = 1'b0;
      cyc(4);
      wr_n = 1'b1;
      cyc(5);
   endtask

   // Sample while strobe is low, after output enable has caught up
   task automatic rd(output logic [7:0] d, output logic oe);
      rd_n = 1'b0;
      cyc(4);
      d = dout;
      oe = doe;
      rd_n = 1'b1;
      cyc(4);
   endtask

   // Expected memory word, worked out independently of the model
   function automatic logic [17:0] pat(input logic [8:0] c,
                                       input logic [8:0] r);
      pat = {c[5:0] + 6'h11, r[5:0] + 6'h22, c[5:0] ^ r[5:0] ^ 6'h33};
   endfunction

   // Three bytes of one pixel, six bits each, MSB aligned
   task automatic rd_pix(input logic [8:0] c, input logic [8:0] r,
                         input logic bgr);
      logic [17:0] p;
      logic [7:0] b;
      logic oe;
      int n;
      p = pat(c, r);
      n = fetch_cnt;
      rd(b, oe);
      chk(b, {bgr ? p[5:0] : p[17:12], 2'b00});
      rd(b, oe);
      chk(b, {p[11:6], 2'b00});
      rd(b, oe);
      chk(b, {bgr ? p[17:12] : p[5:0], 2'b00});
      chk(18'(fetch_cnt - n), 18'h00001);
   endtask

   // Set access byte, start a read, expect dummy then first pixel
   task automatic rd_run(input logic [7:0] m, input logic [8:0] c,
                         input logic [8:0] r);
      logic [7:0] b;
      logic oe;
      int n;
      wr(1'b0, 8'h36);
      wr(1'b1, m);
      n = fetch_cnt;
      wr(1'b0, 8'h2E);
      chk(18'(fetch_cnt - n), 18'h00001);
      chk(fcol, c);
      chk(frow, r);
      rd(b, oe);
      chk(b, 8'h00);
      chk(oe, 1'b1);
      rd_pix(c, r, m[3]);
   endtask

   // Blanking levels in, pin compared after its register lag
   task automatic sync_chk(input logic v, input logic h, input logic e);
      vb = v;
      hb = h;
      cyc(2);
      chk(fsync, e);
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Whole run is about 600 cycles; cut a hang at 5000
   initial begin
      #500000;
      error_cnt++;
      end_sim();
   end

   initial begin
      logic [7:0] b;
      logic oe;
      cyc(20);
      rst_n = 1'b1;
      cyc(3);
      chk(top, 9'h000);
      chk(scr, 9'h186);
      chk(bot, 9'h000);
      chk(mac, 8'h00);
      wr(1'b0, 8'h36);
      wr(1'b1, 8'hA5);
      chk(mac, 8'hA4);
      // Geometry sums to the full panel height
      wr(1'b0, 8'h33);
      foreach (sp[i]) wr(1'b1, sp[i]);
      chk(top, 9'h123);
      chk(scr, 9'h045);
      chk(bot, 9'h01E);
      // Scroll entry: windows, access byte with swap clear, image, pointer
      wr(1'b0, 8'h2A);
      foreach (cwin[i]) wr(1'b1, cwin[i]);
      wr(1'b0, 8'h2B);
      foreach (rwin[i]) wr(1'b1, rwin[i]);
      wr(1'b0, 8'h36);
      wr(1'b1, 8'h00);
      wr(1'b0, 8'h2C);
      wr(1'b1, 8'h3F);
      wr(1'b0, 8'h37);
      wr(1'b1, 8'h00);
      wr(1'b1, 8'h03);
      chk(top, 9'h123);
      chk(scr, 9'h045);
      chk(bot, 9'h01E);
      chk(mac, 8'h00);
      sync_chk(1'b1, 1'b0, 1'b0);
      wr(1'b0, 8'h35);
      wr(1'b1, 8'h00);
      sync_chk(1'b1, 1'b0, 1'b1);
      sync_chk(1'b0, 1'b1, 1'b0);
      wr(1'b0, 8'h35);
      wr(1'b1, 8'h01);
      sync_chk(1'b0, 1'b1, 1'b1);
      // Refresh line flip must leave the pin alone
      wr(1'b0, 8'h36);
      wr(1'b1, 8'h10);
      chk(fsync, 1'b1);
      chk(mac, 8'h10);
      slp = 1'b1;
      sync_chk(1'b1, 1'b1, 1'b0);
      slp = 1'b0;
      sync_chk(1'b1, 1'b1, 1'b1);
      // Second off command finds the pin already off
      for (int k = 0; k < 2; k++) begin
         wr(1'b0, 8'h34);
         sync_chk(1'b1, 1'b1, 1'b0);
      end
      soft_rst = 1'b1;
      cyc(1);
      soft_rst = 1'b0;
      cyc(1);
      chk(top, 9'h000);
      chk(scr, 9'h186);
      chk(bot, 9'h000);
      chk(mac, 8'h10);
      wr(1'b0, 8'h3A);
      wr(1'b1, 8'h66);
      rd_run(8'h00, 9'h000, 9'h000);
      rd_pix(9'h001, 9'h000, 1'b0);
      rd_run(8'hC8, 9'h167, 9'h185);
      // Any command but a read ends the burst; later strobes drive nothing
      wr(1'b0, 8'h00);
      rd(b, oe);
      chk(oe, 1'b0);
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      cyc(3);
      chk(mac, 8'h00);
      rd_run(8'h40, 9'h167, 9'h000);
      end_sim();
   end
endmodule

// *** hw/dsc_defs.svh ***
// Constants of the display scroll, sync and access command block
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
// Command codes
`define DSC_CMD_FRAME_MEMORY_READ 8'h2E
`define DSC_CMD_SCROLL_AREA_DEFINE 8'h33
`define DSC_CMD_SYNC_OUTPUT_OFF 8'h34
`define DSC_CMD_SYNC_OUTPUT_ON 8'h35
`define DSC_CMD_MEMORY_ACCESS_CONTROL 8'h36
// Number of parameters per command
`define DSC_NPAR_SCROLL 3'h6
`define DSC_NPAR_ONE 3'h1
// Reset values
`define DSC_RST_TOP_FIXED 9'h000
`define DSC_RST_SCROLL_AREA 9'h186
`define DSC_RST_BOTTOM_FIXED 9'h000
`define DSC_RST_MAC 8'h00
// Memory access control bit positions
`define DSC_MAC_ROW_REV 7
`define DSC_MAC_COL_REV 6
`define DSC_MAC_SWAP 5
`define DSC_MAC_LINE_DIR 4
`define DSC_MAC_BGR 3
`define DSC_MAC_COL_DIR 2
`define DSC_MAC_HSCROLL 1
// Sync output mode bit position in the sync on parameter
`define DSC_SYNC_KIND_BIT 0
// Frame memory geometry: last column and last row index
`define DSC_COL_LAST 9'h167
`define DSC_ROW_LAST 9'h185
// Read stream
`define DSC_READ_DUMMY 8'h00
`define DSC_BYTE_DUMMY 2'h0
`define DSC_BYTE_RED 2'h1
`define DSC_BYTE_GREEN 2'h2
`define DSC_BYTE_BLUE 2'h3
// Pin synchroniser width and idle level (strobes idle high)
`define DSC_SYNC_W 11
`define DSC_SYNC_IDLE 11'h7FF
`endif

// *** hw/dsc_pkg.sv ***
// Types of the display scroll, sync and access command block
package dsc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PARAM = 3'b010,
      ST_READ = 3'b100
   } dsc_state_type;

   typedef struct packed {
      dsc_state_type state;
      logic [7:0] cmd;
      logic [2:0] pidx;
      logic [8:0] top_fixed_lines;
      logic [8:0] scroll_area_lines;
      logic [8:0] bottom_fixed_lines;
      logic [7:0] mac;
      logic sync_en;
      logic sync_output_kind;
      logic frame_sync;
      logic [8:0] x;
      logic [8:0] y;
      logic [8:0] col;
      logic [8:0] row;
      logic [1:0] byte_idx;
      logic [17:0] pix;
      logic load_pend;
      logic fm_rd;
      logic [7:0] dout;
      logic doe;
      logic prev_wr;
      logic prev_rd;
   } dsc_regs_type;
endpackage

// *** hw/dsc_sync2.sv ***
// Two-flop synchroniser for the command interface pins
`timescale 1ns/100ps
`include "dsc_defs.svh"
module dsc_sync2 (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [`DSC_SYNC_W-1:0] d_i,
   output logic [`DSC_SYNC_W-1:0] q_o
);
   logic [`DSC_SYNC_W-1:0] meta_r;

   // First stage feeds only the second; idle high so no false edge at reset
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_r <= `DSC_SYNC_IDLE;
         q_o <= `DSC_SYNC_IDLE;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule

// *** hw/dsc_top.sv ***
// Command interpreter for frame read, scroll area, sync output, access ctrl
`timescale 1ns/100ps
`include "dsc_defs.svh"
module dsc_top
   import dsc_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic SOFT_RESET_I,
   input wire logic WR_N_I,
   input wire logic RD_N_I,
   input wire logic DATA_COMMAND_SELECT_I,
   input wire logic [7:0] DATA_I,
   output logic [7:0] DATA_O,
   output logic DATA_OE_O,
   input wire logic VBLANK_I,
   input wire logic HBLANK_I,
   input wire logic SLEEP_I,
   output logic FRAME_SYNC_O,
   output logic [8:0] FM_COL_O,
   output logic [8:0] FM_ROW_O,
   output logic FM_RD_O,
   input wire logic [17:0] FM_DATA_I,
   output logic [8:0] TOP_FIXED_LINES_O,
   output logic [8:0] SCROLL_AREA_LINES_O,
   output logic [8:0] BOTTOM_FIXED_LINES_O,
   output logic [7:0] MEMORY_ACCESS_CONTROL_O
);
   dsc_regs_type st_r;
   dsc_regs_type st_nxt;
   logic [`DSC_SYNC_W-1:0] pin_s;
   logic s_wr;
   logic s_rd;
   logic s_dcx;
   logic [7:0] s_data;
   logic wr_rise;
   logic rd_rise;
   logic cmd_stb;
   logic par_stb;
   logic [8:0] x_last;
   logic [8:0] y_last;
   logic [8:0] ax;
   logic [8:0] ay;
   logic [17:0] pix_in;

   // Pins are asynchronous to the core clock
   dsc_sync2 u_sync (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .d_i({WR_N_I, RD_N_I, DATA_COMMAND_SELECT_I, DATA_I}),
      .q_o(pin_s)
   );

   // Strobe edges seen after synchronisation
   assign s_wr = pin_s[10];
   assign s_rd = pin_s[9];
   assign s_dcx = pin_s[8];
   assign s_data = pin_s[7:0];
   assign wr_rise = s_wr & ~st_r.prev_wr;
   assign rd_rise = s_rd & ~st_r.prev_rd;
   assign cmd_stb = wr_rise & ~s_dcx;
   assign par_stb = wr_rise & s_dcx;

   // Logical scan limits swap with the row/column exchange
   assign x_last = st_r.mac[`DSC_MAC_SWAP] ? `DSC_ROW_LAST : `DSC_COL_LAST;
   assign y_last = st_r.mac[`DSC_MAC_SWAP] ? `DSC_COL_LAST : `DSC_ROW_LAST;

   // Subpixel order applied as the pixel is fetched
   assign pix_in = st_r.mac[`DSC_MAC_BGR] ?
      {FM_DATA_I[5:0], FM_DATA_I[11:6], FM_DATA_I[17:12]} : FM_DATA_I;

   // Next state of the whole block
   always_comb begin
      st_nxt = st_r;
      ax = 9'h000;
      ay = 9'h000;
      st_nxt.prev_wr = s_wr;
      st_nxt.prev_rd = s_rd;
      st_nxt.fm_rd = 1'b0;
      // Sync pin: timing never looks at the refresh line direction bit
      st_nxt.frame_sync = st_r.sync_en & ~SLEEP_I &
         (VBLANK_I | (st_r.sync_output_kind & HBLANK_I));
      // Fetched word lands one cycle after the address moved
      if (st_r.load_pend) begin
         st_nxt.pix = pix_in;
         st_nxt.load_pend = 1'b0;
      end
      if (cmd_stb) begin
         // A fresh command ends a read burst; a read command restarts it
         st_nxt.cmd = s_data;
         st_nxt.pidx = 3'h0;
         st_nxt.state = ST_PARAM;
         unique case (s_data)
            `DSC_CMD_FRAME_MEMORY_READ: begin
               st_nxt.state = ST_READ;
               st_nxt.x = 9'h000;
               st_nxt.y = 9'h000;
               st_nxt.byte_idx = `DSC_BYTE_DUMMY;
               st_nxt.dout = `DSC_READ_DUMMY;
               st_nxt.load_pend = 1'b1;
               st_nxt.fm_rd = 1'b1;
            end
            `DSC_CMD_SYNC_OUTPUT_OFF: begin
               st_nxt.state = ST_IDLE;
               st_nxt.sync_en = 1'b0;
            end
            `DSC_CMD_SCROLL_AREA_DEFINE,
            `DSC_CMD_SYNC_OUTPUT_ON,
            `DSC_CMD_MEMORY_ACCESS_CONTROL: begin
               st_nxt.state = ST_PARAM;
            end
            default: begin
               st_nxt.state = ST_IDLE;
            end
         endcase
      end else if (par_stb && st_r.state == ST_PARAM) begin
         // Parameters are taken in order; extras are ignored
         st_nxt.pidx = st_r.pidx + 3'h1;
         unique case (st_r.cmd)
            `DSC_CMD_SCROLL_AREA_DEFINE: begin
               // Only the geometry is stored; no scroll is started
               unique case (st_r.pidx)
                  3'h0: st_nxt.top_fixed_lines[8] = s_data[0];
                  3'h1: st_nxt.top_fixed_lines[7:0] = s_data;
                  3'h2: st_nxt.scroll_area_lines[8] = s_data[0];
                  3'h3: st_nxt.scroll_area_lines[7:0] = s_data;
                  3'h4: st_nxt.bottom_fixed_lines[8] = s_data[0];
                  3'h5: st_nxt.bottom_fixed_lines[7:0] = s_data;
                  default: st_nxt.pidx = st_r.pidx;
               endcase
               if (st_r.pidx == `DSC_NPAR_SCROLL - 3'h1) begin
                  st_nxt.state = ST_IDLE;
               end
            end
            `DSC_CMD_SYNC_OUTPUT_ON: begin
               st_nxt.sync_en = 1'b1;
               st_nxt.sync_output_kind = s_data[`DSC_SYNC_KIND_BIT];
               st_nxt.state = ST_IDLE;
            end
            `DSC_CMD_MEMORY_ACCESS_CONTROL: begin
               // Bit 0 is unused and kept at zero
               st_nxt.mac = {s_data[7:1], 1'b0};
               st_nxt.state = ST_IDLE;
            end
            default: begin
               st_nxt.state = ST_IDLE;
            end
         endcase
      end else if (rd_rise && st_r.state == ST_READ) begin
         // Each read strobe moves to the next byte of the stream
         unique case (st_r.byte_idx)
            `DSC_BYTE_DUMMY, `DSC_BYTE_BLUE: begin
               st_nxt.byte_idx = `DSC_BYTE_RED;
               st_nxt.dout = {st_r.pix[17:12], 2'b00};
            end
            `DSC_BYTE_RED: begin
               st_nxt.byte_idx = `DSC_BYTE_GREEN;
               st_nxt.dout = {st_r.pix[11:6], 2'b00};
            end
            `DSC_BYTE_GREEN: begin
               // Last subpixel out: step the pointer and fetch ahead
               st_nxt.byte_idx = `DSC_BYTE_BLUE;
               st_nxt.dout = {st_r.pix[5:0], 2'b00};
               st_nxt.load_pend = 1'b1;
               st_nxt.fm_rd = 1'b1;
               if (st_r.x == x_last) begin
                  st_nxt.x = 9'h000;
                  st_nxt.y = (st_r.y == y_last) ? 9'h000 : st_r.y + 9'h001;
               end else begin
                  st_nxt.x = st_r.x + 9'h001;
               end
            end
         endcase
      end
      // Physical address from logical pointers and access control
      ax = st_r.mac[`DSC_MAC_COL_REV] ? x_last - st_nxt.x : st_nxt.x;
      ay = st_r.mac[`DSC_MAC_ROW_REV] ? y_last - st_nxt.y : st_nxt.y;
      st_nxt.col = st_r.mac[`DSC_MAC_SWAP] ? ay : ax;
      st_nxt.row = st_r.mac[`DSC_MAC_SWAP] ? ax : ay;
      // Bus driven only while the host strobes a read
      st_nxt.doe = (st_nxt.state == ST_READ) & ~s_rd;
      // Soft reset restores geometry and sync, but keeps access control
      if (SOFT_RESET_I) begin
         st_nxt.state = ST_IDLE;
         st_nxt.top_fixed_lines = `DSC_RST_TOP_FIXED;
         st_nxt.scroll_area_lines = `DSC_RST_SCROLL_AREA;
         st_nxt.bottom_fixed_lines = `DSC_RST_BOTTOM_FIXED;
         st_nxt.sync_en = 1'b0;
         st_nxt.sync_output_kind = 1'b0;
         st_nxt.frame_sync = 1'b0;
         st_nxt.doe = 1'b0;
      end
   end

   // Frame memory itself lives outside and is never touched by reset
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         st_r <= '0;
         st_r.state <= ST_IDLE;
         st_r.top_fixed_lines <= `DSC_RST_TOP_FIXED;
         st_r.scroll_area_lines <= `DSC_RST_SCROLL_AREA;
         st_r.bottom_fixed_lines <= `DSC_RST_BOTTOM_FIXED;
         st_r.mac <= `DSC_RST_MAC;
         st_r.prev_wr <= 1'b1;
         st_r.prev_rd <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state flops
   assign DATA_O = st_r.dout;
   assign DATA_OE_O = st_r.doe;
   assign FRAME_SYNC_O = st_r.frame_sync;
   assign FM_COL_O = st_r.col;
   assign FM_ROW_O = st_r.row;
   assign FM_RD_O = st_r.fm_rd;
   assign TOP_FIXED_LINES_O = st_r.top_fixed_lines;
   assign SCROLL_AREA_LINES_O = st_r.scroll_area_lines;
   assign BOTTOM_FIXED_LINES_O = st_r.bottom_fixed_lines;
   assign MEMORY_ACCESS_CONTROL_O = st_r.mac;

   // Checks
   sequence s_read_cmd;
      cmd_stb && s_data == `DSC_CMD_FRAME_MEMORY_READ && !SOFT_RESET_I;
   endsequence

   sequence s_soft_rst;
      SOFT_RESET_I;
   endsequence

   chk_read_abort: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (st_r.state == ST_READ && cmd_stb &&
       s_data != `DSC_CMD_FRAME_MEMORY_READ) |=> st_r.state != ST_READ)
      else $error("read burst not aborted by new command");

   chk_read_coding: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      st_r.state == ST_READ |-> st_r.dout[1:0] == 2'b00)
      else $error("read byte not in 18-bit coding");

   chk_dummy_first: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      s_read_cmd |=> (st_r.dout == `DSC_READ_DUMMY &&
       st_r.byte_idx == `DSC_BYTE_DUMMY && FM_RD_O) ##1 !FM_RD_O)
      else $error("read did not start with dummy byte");

   chk_pointer_reload: assert property (@(posedge CLK_I)
      disable iff (!RESET_N_I)
      (s_read_cmd ##0 !st_r.mac[`DSC_MAC_SWAP]) |=>
      FM_COL_O == (st_r.mac[`DSC_MAC_COL_REV] ? `DSC_COL_LAST : 9'h000) &&
      FM_ROW_O == (st_r.mac[`DSC_MAC_ROW_REV] ? `DSC_ROW_LAST : 9'h000))
      else $error("pointers not reloaded to start position");

   chk_scroll_reset: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      s_soft_rst |=> TOP_FIXED_LINES_O == 9'h000 &&
      SCROLL_AREA_LINES_O == 9'h186 && BOTTOM_FIXED_LINES_O == 9'h000)
      else $error("scroll geometry not reset");

   chk_mac_keep: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (s_soft_rst ##0 !par_stb) |=> $stable(MEMORY_ACCESS_CONTROL_O))
      else $error("access control changed by soft reset");

   chk_mac_bit0: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      MEMORY_ACCESS_CONTROL_O[0] == 1'b0)
      else $error("unused access control bit set");

   chk_sync_off: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (cmd_stb && s_data == `DSC_CMD_SYNC_OUTPUT_OFF) |=>
      ##1 !FRAME_SYNC_O [*2])
      else $error("sync pin not held low after off");

   chk_sync_sleep: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      SLEEP_I |=> !FRAME_SYNC_O)
      else $error("sync pin not low in sleep");

   chk_sync_kind: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (st_r.sync_en && !SLEEP_I && !SOFT_RESET_I && HBLANK_I) |=>
      FRAME_SYNC_O == ($past(VBLANK_I) |
      $past(st_r.sync_output_kind)))
      else $error("sync pin mode wrong");

   chk_top_param: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      (par_stb && st_r.state == ST_PARAM && !SOFT_RESET_I &&
       st_r.cmd == `DSC_CMD_SCROLL_AREA_DEFINE && st_r.pidx == 3'h1) |=>
      TOP_FIXED_LINES_O[7:0] == $past(s_data))
      else $error("top fixed low byte not stored");
endmodule
